//--- common/atl_defines.vh
`ifndef ATL_DEFINES_VH
`define ATL_DEFINES_VH
// Register indices; the bus byte address is four times the index
`define ATL_IDX_MODE 8'h06
`define ATL_IDX_ATTACK_RATE_VALUE 8'h07
`define ATL_IDX_LIMITER_RELEASE_RATE 8'h08
`define ATL_IDX_RAMPMIX 8'h09
`define ATL_IDX_SPEED 8'h0A
`define ATL_IDX_TONE 8'h05
`define ATL_IDX_STATUS 8'h10
// Reset values
`define ATL_RST_MODE 8'h00
`define ATL_RST_ATTACK_RATE_VALUE 8'h10
`define ATL_RST_LIMITER_RELEASE_RATE 8'h20
`define ATL_RST_RAMPMIX 8'h09
`define ATL_RST_TONE 8'h00
// Mode register fields
`define ATL_MODE_BCF_HI 7
`define ATL_MODE_BCF_LO 6
`define ATL_MODE_TCF_HI 5
`define ATL_MODE_TCF_LO 4
`define ATL_MODE_TC_HI 3
`define ATL_MODE_TC_LO 2
`define ATL_MODE_TEN 1
`define ATL_MODE_LEN 0
// Ramp/mix fields
`define ATL_RMP_HI 5
`define ATL_RMP_LO 4
`define ATL_MIXA_HI 3
`define ATL_MIXA_LO 2
`define ATL_MIXB_HI 1
`define ATL_MIXB_LO 0
// Speed register field
`define ATL_SPEED_DBS 4
// Limiter rate numerators, in eighth-sample units
`define ATL_ATK_NUM 16'h0100
`define ATL_REL_NUM 16'h1000
// Ramp times in milliseconds
`define ATL_RAMP_MS0 100
`define ATL_RAMP_MS1 200
`define ATL_RAMP_MS2 300
`define ATL_RAMP_MS3 650
`define ATL_CLK_MHZ 40
// Full-scale clip level and max boost (dB)
`define ATL_CLIP_LEVEL 24'h7FFFFF
`define ATL_MAX_BOOST 4'hC
`endif

//--- logic/atl_top.v
`timescale 1ns/1ps
`include "atl_defines.vh"
module atl_top (
  input wire mclk,
  input wire rst,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hsel,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire sample_clock,
  input wire [23:0] left_in,
  input wire [23:0] right_in,
  input wire clip_detect,
  input wire ramp_up_req,
  output reg [23:0] output_a,
  output reg [23:0] output_b,
  output reg [7:0] bass_gain,
  output reg [7:0] treble_gain,
  output reg [15:0] bass_coef,
  output reg [15:0] treble_coef,
  output reg [7:0] limiter_atten,
  output reg [15:0] pwm_duty,
  output reg ramp_done
);

  function [23:0] mix_pick;
    input [1:0] sel;
    input [23:0] l;
    input [23:0] r;
    reg [24:0] sum;
    begin
      sum = {l[23], l} + {r[23], r};
      case (sel)
        2'b01: mix_pick = r;
        2'b10: mix_pick = l;
        2'b11: mix_pick = sum[24:1];
        default: mix_pick = 24'h000000;
      endcase
    end
  endfunction

  // Corner coefficient at 48 kHz; per-sample units track the sample rate
  function [15:0] bass_cf;
    input [1:0] code;
    begin
      case (code)
        2'b00: bass_cf = 16'h0036;
        2'b01: bass_cf = 16'h006B;
        2'b10: bass_cf = 16'h00D6;
        default: bass_cf = 16'h0000;
      endcase
    end
  endfunction

  function [15:0] treble_cf;
    input [1:0] code;
    begin
      case (code)
        2'b00: treble_cf = 16'h0AAB;
        2'b01: treble_cf = 16'h1555;
        2'b10: treble_cf = 16'h2555;
        default: treble_cf = 16'h0000;
      endcase
    end
  endfunction

  localparam RAMP_MAX = 16'h8000;
  localparam [31:0] RAMP_C0 = `ATL_RAMP_MS0 * `ATL_CLK_MHZ * 1000 / 32768;
  localparam [31:0] RAMP_C1 = `ATL_RAMP_MS1 * `ATL_CLK_MHZ * 1000 / 32768;
  localparam [31:0] RAMP_C2 = `ATL_RAMP_MS2 * `ATL_CLK_MHZ * 1000 / 32768;
  localparam [31:0] RAMP_C3 = `ATL_RAMP_MS3 * `ATL_CLK_MHZ * 1000 / 32768;

  localparam ST_IDLE = 3'b001;
  localparam ST_ATTACK = 3'b010;
  localparam ST_RELEASE = 3'b100;

  reg [7:0] mode_reg;
  reg [7:0] attack_rate_value;
  reg [7:0] release_rate_value;
  reg [7:0] rampmix_reg;
  reg [7:0] tone_reg;
  reg double_speed_select;
  reg [2:0] lim_state;
  reg [7:0] lim_bass_cut;
  reg [7:0] lim_treble_cut;
  reg [15:0] step_acc;

  // AHB-Lite slave: zero wait states, OKAY always
  reg wr_pend;
  reg [7:0] wr_addr;
  reg rd_pend;
  reg [7:0] rd_addr;
  wire take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire [1:0] bass_corner_select = mode_reg[`ATL_MODE_BCF_HI:`ATL_MODE_BCF_LO];
  wire [1:0] treble_corner_select =
    mode_reg[`ATL_MODE_TCF_HI:`ATL_MODE_TCF_LO];
  wire [1:0] tone_preset_mode = mode_reg[`ATL_MODE_TC_HI:`ATL_MODE_TC_LO];
  wire tone_enable = mode_reg[`ATL_MODE_TEN];
  wire limiter_enable = mode_reg[`ATL_MODE_LEN];
  wire [1:0] ramp_speed_select = rampmix_reg[`ATL_RMP_HI:`ATL_RMP_LO];

  always @(posedge mclk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
    end else begin
      wr_pend <= take && hwrite;
      rd_pend <= take && !hwrite;
      wr_addr <= haddr[9:2];
      rd_addr <= haddr[9:2];
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      mode_reg <= `ATL_RST_MODE;
      attack_rate_value <= `ATL_RST_ATTACK_RATE_VALUE;
      release_rate_value <= `ATL_RST_LIMITER_RELEASE_RATE;
      rampmix_reg <= `ATL_RST_RAMPMIX;
      tone_reg <= `ATL_RST_TONE;
      double_speed_select <= 1'b0;
    end else if (wr_pend) begin
      case (wr_addr)
        `ATL_IDX_MODE: mode_reg <= hwdata[7:0];
        `ATL_IDX_ATTACK_RATE_VALUE: attack_rate_value <= hwdata[7:0];
        `ATL_IDX_LIMITER_RELEASE_RATE: release_rate_value <= hwdata[7:0];
        `ATL_IDX_RAMPMIX: rampmix_reg <= {2'b00, hwdata[5:0]};
        `ATL_IDX_TONE: tone_reg <= hwdata[7:0];
        `ATL_IDX_SPEED: double_speed_select <= hwdata[`ATL_SPEED_DBS];
        default: ;
      endcase
    end
  end

  always @* begin
    hrdata = 32'h00000000;
    if (rd_pend) begin
      case (rd_addr)
        `ATL_IDX_MODE: hrdata = {24'h000000, mode_reg};
        `ATL_IDX_ATTACK_RATE_VALUE: hrdata = {24'h000000, attack_rate_value};
        `ATL_IDX_LIMITER_RELEASE_RATE: hrdata = {24'h000000, release_rate_value};
        `ATL_IDX_RAMPMIX: hrdata = {24'h000000, rampmix_reg};
        `ATL_IDX_TONE: hrdata = {24'h000000, tone_reg};
        `ATL_IDX_SPEED: hrdata = {27'h0000000, double_speed_select, 4'h0};
        `ATL_IDX_STATUS:
          hrdata = {15'h0000, ramp_done, limiter_atten, 5'h00, lim_state};
        default: hrdata = 32'h00000000;
      endcase
    end
  end

  // Sample clock from the pin: two flops, then edge detect on the second
  reg sc_m;
  reg sc_s;
  reg sc_d;
  wire sample_tick = sc_s && !sc_d;
  always @(posedge mclk) begin
    if (rst) begin
      sc_m <= 1'b0;
      sc_s <= 1'b0;
      sc_d <= 1'b0;
    end else begin
      sc_m <= sample_clock;
      sc_s <= sc_m;
      sc_d <= sc_s;
    end
  end

  reg clip_m;
  reg clip_s;
  always @(posedge mclk) begin
    if (rst) begin
      clip_m <= 1'b0;
      clip_s <= 1'b0;
    end else begin
      clip_m <= clip_detect;
      clip_s <= clip_m;
    end
  end

  // Mixing ahead of the volume stage
  always @(posedge mclk) begin
    if (rst) begin
      output_a <= 24'h000000;
      output_b <= 24'h000000;
    end else if (sample_tick) begin
      output_a <= mix_pick(rampmix_reg[`ATL_MIXA_HI:`ATL_MIXA_LO],
                           left_in, right_in);
      output_b <= mix_pick(rampmix_reg[`ATL_MIXB_HI:`ATL_MIXB_LO],
                           left_in, right_in);
    end
  end

  // User or preset levels and corners
  reg [3:0] user_bass;
  reg [3:0] user_treble;
  reg [1:0] eff_bcf;
  reg [1:0] eff_tcf;
  always @* begin
    case (tone_preset_mode)
      2'b01: begin
        user_bass = 4'hC;
        user_treble = 4'h6;
      end
      2'b10: begin
        user_bass = 4'h8;
        user_treble = 4'h4;
      end
      2'b11: begin
        user_bass = 4'h4;
        user_treble = 4'h2;
      end
      default: begin
        user_bass = (tone_reg[7:4] > `ATL_MAX_BOOST) ?
          `ATL_MAX_BOOST : tone_reg[7:4];
        user_treble = (tone_reg[3:0] > `ATL_MAX_BOOST) ?
          `ATL_MAX_BOOST : tone_reg[3:0];
      end
    endcase
    eff_bcf = (tone_preset_mode == 2'b00) ? bass_corner_select : 2'b01;
    eff_tcf = (tone_preset_mode == 2'b00) ? treble_corner_select : 2'b10;
  end

  // Levels in eighth-dB units
  wire [7:0] bass_target = {1'b0, user_bass, 3'b000};
  wire [7:0] treble_target = {1'b0, user_treble, 3'b000};
  // Rate accumulator: one step per sample adds value; 256 eighth-sample
  // units of attack (4096 release) equal 32 (512) samples.
  wire [15:0] rate_num = (lim_state == ST_ATTACK) ?
    `ATL_ATK_NUM : `ATL_REL_NUM;
  wire [7:0] rate_val = (lim_state == ST_ATTACK) ?
    attack_rate_value : release_rate_value;
  wire [16:0] acc_sum = {1'b0, step_acc} + {6'h00, rate_val, 3'b000};
  wire step_now = acc_sum >= {1'b0, rate_num};

  // Limiter sequencing
  always @(posedge mclk) begin
    if (rst || !limiter_enable) begin
      lim_state <= ST_IDLE;
      lim_bass_cut <= 8'h00;
      lim_treble_cut <= 8'h00;
      limiter_atten <= 8'h00;
      step_acc <= 16'h0000;
    end else if (sample_tick) begin
      case (lim_state)
        ST_IDLE: begin
          step_acc <= 16'h0000;
          if (clip_s)
            lim_state <= ST_ATTACK;
          else if (lim_bass_cut != 8'h00 || limiter_atten != 8'h00)
            lim_state <= ST_RELEASE;
        end
        ST_ATTACK: begin
          if (!clip_s) begin
            lim_state <= ST_RELEASE;
            step_acc <= 16'h0000;
          end else if (step_now) begin
            step_acc <= acc_sum[15:0] - rate_num;
            if (lim_bass_cut < bass_target ||
                lim_treble_cut < treble_target) begin
              if (lim_bass_cut < bass_target)
                lim_bass_cut <= lim_bass_cut + 8'h01;
              if (lim_treble_cut < treble_target)
                lim_treble_cut <= lim_treble_cut + 8'h01;
            end else if (limiter_atten != 8'hFF)
              limiter_atten <= limiter_atten + 8'h01;
          end else
            step_acc <= acc_sum[15:0];
        end
        ST_RELEASE: begin
          if (clip_s) begin
            lim_state <= ST_ATTACK;
            step_acc <= 16'h0000;
          end else if (step_now) begin
            step_acc <= acc_sum[15:0] - rate_num;
            if (limiter_atten != 8'h00)
              limiter_atten <= limiter_atten - 8'h01;
            else if (lim_bass_cut != 8'h00)
              lim_bass_cut <= lim_bass_cut - 8'h01;
            else begin
              lim_treble_cut <= 8'h00;
              lim_state <= ST_IDLE;
            end
          end else
            step_acc <= acc_sum[15:0];
        end
        default: lim_state <= ST_IDLE;
      endcase
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      bass_gain <= 8'h00;
      treble_gain <= 8'h00;
      bass_coef <= 16'h0000;
      treble_coef <= 16'h0000;
    end else begin
      bass_gain <= (!tone_enable || lim_bass_cut >= bass_target) ?
        8'h00 : bass_target - lim_bass_cut;
      treble_gain <= (!tone_enable || double_speed_select ||
                      lim_treble_cut >= treble_target) ?
        8'h00 : treble_target - lim_treble_cut;
      // Per-sample bass coefficient halves at double rate; treble coefficient is zeroed
      bass_coef <= double_speed_select ?
        (bass_cf(eff_bcf) >> 1) : bass_cf(eff_bcf);
      treble_coef <= double_speed_select ? 16'h0000 : treble_cf(eff_tcf);
    end
  end

  // Ramp step spacing from speed code
  reg [31:0] ramp_cycles;
  always @* begin
    case (ramp_speed_select)
      2'b00: ramp_cycles = RAMP_C0;
      2'b01: ramp_cycles = RAMP_C1;
      2'b10: ramp_cycles = RAMP_C2;
      default: ramp_cycles = RAMP_C3;
    endcase
  end

  reg ru_m;
  reg ru_s;
  reg [15:0] ramp_cnt;
  reg [15:0] ramp_level;
  wire ramp_step = ramp_cnt >= ramp_cycles[15:0] - 16'h0001;
  // Linear ramp between zero and the 50% bias point
  always @(posedge mclk) begin
    if (rst) begin
      ru_m <= 1'b0;
      ru_s <= 1'b0;
      ramp_cnt <= 16'h0000;
      ramp_level <= 16'h0000;
      pwm_duty <= 16'h0000;
      ramp_done <= 1'b0;
    end else begin
      ru_m <= ramp_up_req;
      ru_s <= ru_m;
      ramp_cnt <= ramp_step ? 16'h0000 : ramp_cnt + 16'h0001;
      if (ramp_step) begin
        if (ru_s && ramp_level != RAMP_MAX)
          ramp_level <= ramp_level + 16'h0001;
        else if (!ru_s && ramp_level != 16'h0000)
          ramp_level <= ramp_level - 16'h0001;
      end
      pwm_duty <= ramp_level;
      ramp_done <= ru_s ? (ramp_level == RAMP_MAX) : (ramp_level == 16'h0000);
    end
  end

endmodule // atl_top

//--- dv/atl_properties.sv
`timescale 1ns/1ps
module atl_properties (
  input wire mclk,
  input wire rst,
  input wire hsel,
  input wire hready,
  input wire [1:0] htrans,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire sample_clock,
  input wire [23:0] output_a,
  input wire [23:0] output_b,
  input wire [7:0] bass_gain,
  input wire [7:0] treble_gain,
  input wire [7:0] limiter_atten,
  input wire [15:0] pwm_duty,
  input wire ramp_done
);
  reg sc_q;
  reg dphase;
  reg [7:0] since_tick;
  // Saturates so a stalled sample clock cannot wrap into a false tick
  always @(posedge mclk) begin
    sc_q <= sample_clock;
    dphase <= hsel & hready & htrans[1];
    if (rst) since_tick <= 8'hFF;
    else if (sample_clock & ~sc_q) since_tick <= 8'h00;
    else if (since_tick != 8'hFF) since_tick <= since_tick + 8'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_atten_up;
    limiter_atten > $past(limiter_atten);
  endsequence
  sequence s_no_rise;
    (limiter_atten <= $past(limiter_atten)) [*8];
  endsequence
  a_zero_wait_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait OKAY");
  a_rdata_idle: assert property (!dphase |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_cut_first: assert property (
    s_atten_up |-> $past(bass_gain) == 8'h00 && $past(treble_gain) == 8'h00)
    else $error("attenuation rose while boost remained");
  a_atten_then_bass: assert property (
    bass_gain > $past(bass_gain) |-> $past(limiter_atten) == 8'h00)
    else $error("bass returned before attenuation");
  a_attack_paced: assert property (s_atten_up |=> s_no_rise)
    else $error("two attack steps within one sample");
  a_eighth_step: assert property (
    s_atten_up |-> limiter_atten == $past(limiter_atten) + 8'h01)
    else $error("attenuation step not one unit");
  a_duty_bias: assert property (pwm_duty <= 16'h8000)
    else $error("duty beyond bias point");
  a_duty_linear: assert property (
    pwm_duty != $past(pwm_duty) |-> pwm_duty == $past(pwm_duty) + 16'h0001
      || pwm_duty == $past(pwm_duty) - 16'h0001)
    else $error("duty jumped");
  a_done_at_end: assert property (
    ramp_done |-> pwm_duty == 16'h0000 || pwm_duty == 16'h8000)
    else $error("ramp done mid ramp");
  a_mix_on_tick: assert property (
    output_a != $past(output_a) || output_b != $past(output_b)
      |-> since_tick <= 8'h08)
    else $error("mixed output moved away from a sample tick");
endmodule // atl_properties
bind atl_top atl_properties atl_properties_inst (.mclk, .rst, .hsel,
  .hready, .htrans, .hrdata, .hreadyout, .hresp, .sample_clock, .output_a,
  .output_b, .bass_gain, .treble_gain, .limiter_atten, .pwm_duty,
  .ramp_done);

//--- dv/atl_sample_src.sv
`timescale 1ns/1ps
module atl_sample_src #(parameter int PER = 32) (
  input wire mclk,
  input wire rst,
  input wire [23:0] l_val,
  input wire [23:0] r_val,
  output logic sample_clock,
  output logic [23:0] left_in,
  output logic [23:0] right_in
);
  int cnt;
  // Samples move in the low half so they are settled at each rise
  always @(posedge mclk) begin
    cnt <= (rst || cnt == PER - 1) ? 0 : cnt + 1;
    sample_clock <= (cnt >= PER / 2);
    if (cnt == 0) begin
      left_in <= l_val;
      right_in <= r_val;
    end
  end
endmodule // atl_sample_src

//--- dv/atl_top_bench.sv
`timescale 1ns/1ps
`include "atl_defines.vh"
module atl_top_bench;
  localparam int PER = 32;
  logic mclk = 1'b0, rst = 1'b1, hwrite = 1'b0, hsel = 1'b0;
  logic clip_detect = 1'b0, ramp_up_req = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [23:0] l_val = 24'h200000, r_val = 24'h100000;
  wire [31:0] hrdata;
  wire hreadyout, hresp, sample_clock, ramp_done;
  wire [23:0] left_in, right_in, output_a, output_b;
  wire [7:0] bass_gain, treble_gain, limiter_atten;
  wire [15:0] bass_coef, treble_coef, pwm_duty;
  int fails = 0, samples_checked = 0;
  int rstep [4] = '{122, 244, 366, 793};
  logic [7:0] ridx [5] = '{`ATL_IDX_MODE, `ATL_IDX_ATTACK_RATE_VALUE, `ATL_IDX_LIMITER_RELEASE_RATE,
    `ATL_IDX_RAMPMIX, `ATL_IDX_TONE};
  logic [7:0] rexp [5] = '{8'h00, 8'h10, 8'h20, 8'h09, 8'h00};
  always #12.5 mclk = ~mclk;
  atl_sample_src #(.PER(PER)) atl_sample_src_inst (.mclk, .rst, .l_val,
    .r_val, .sample_clock, .left_in, .right_in);
  atl_top atl_top_inst (.mclk, .rst, .haddr, .htrans, .hwrite, .hsize,
    .hsel, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .sample_clock, .left_in, .right_in, .clip_detect, .ramp_up_req,
    .output_a, .output_b, .bass_gain, .treble_gain, .bass_coef,
    .treble_coef, .limiter_atten, .pwm_duty, .ramp_done);
  task automatic bus(input [7:0] i, input w, input [7:0] d,
    output [31:0] q);
    haddr <= {22'h0, i, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input [7:0] i, input [7:0] d);
    logic [31:0] q;
    bus(i, 1'b1, d, q);
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp, input string m);
    samples_checked++;
    if (got != exp) begin
      fails++;
      $display("mismatch at %0t: %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n * PER) @(posedge mclk);
  endtask
  // The first change may land mid-interval, so the second is measured
  task automatic gap(input bit duty, output int n);
    logic [15:0] v;
    for (int p = 0; p < 2; p++) begin
      v = duty ? pwm_duty : limiter_atten;
      n = 0;
      while ((duty ? pwm_duty : limiter_atten) === v && n < 5000) begin
        @(posedge mclk);
        #1;
        n++;
      end
    end
    // Back onto the edge so the next drive follows a rising edge
    @(posedge mclk);
  endtask
  function automatic logic [23:0] pick(input logic [1:0] s);
    case (s)
      2'b00: pick = 24'h0;
      2'b01: pick = r_val;
      2'b10: pick = l_val;
      default: pick = l_val / 2 + r_val / 2;
    endcase
  endfunction
  task print_verdict;
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    fails++;
    print_verdict;
  end
  initial begin
    logic [31:0] q;
    logic [15:0] pb, pt;
    int n;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (ridx[i]) begin
      bus(ridx[i], 1'b0, 8'h00, q);
      chk(q, {24'h0, rexp[i]}, "reset value");
    end
    wr(8'h0F, 8'hFF);
    bus(8'h0F, 1'b0, 8'h00, q);
    chk(q, 32'h0, "unmapped");
    wr(`ATL_IDX_RAMPMIX, 8'hFF);
    bus(`ATL_IDX_RAMPMIX, 1'b0, 8'h00, q);
    chk(q, 32'h3F, "reserved bits");
    $display("test registers done");
    for (int m = 0; m < 16; m++) begin
      wr(`ATL_IDX_RAMPMIX, {4'h1, m[3:0]});
      ticks(2);
      chk(output_a, pick(m[3:2]), "output a");
      chk(output_b, pick(m[1:0]), "output b");
    end
    $display("test mixing done");
    wr(`ATL_IDX_TONE, 8'h96);
    wr(`ATL_IDX_MODE, 8'h00);
    ticks(2);
    chk(bass_gain, 0, "tone off");
    wr(`ATL_IDX_MODE, 8'h02);
    ticks(2);
    chk(bass_gain, 72, "user bass");
    chk(treble_gain, 48, "user treble");
    for (int t = 1; t < 4; t++) begin
      wr(`ATL_IDX_MODE, {4'h0, t[1:0], 2'b10});
      ticks(2);
      chk(bass_gain, 32 * (4 - t), "preset bass");
      chk(treble_gain, 16 * (4 - t), "preset treble");
    end
    pb = 16'h0;
    pt = 16'h0;
    for (int c = 0; c < 3; c++) begin
      wr(`ATL_IDX_MODE, {c[1:0], c[1:0], 4'h2});
      ticks(2);
      chk(bass_coef > pb, 1, "bass corner order");
      chk(treble_coef > pt, 1, "treble corner order");
      pb = bass_coef;
      pt = treble_coef;
    end
    wr(`ATL_IDX_SPEED, 8'h10);
    ticks(2);
    chk(bass_coef, pb >> 1, "double speed bass");
    chk(treble_gain, 0, "double speed treble");
    chk(treble_coef, 0, "double speed corner");
    bus(`ATL_IDX_SPEED, 1'b0, 8'h00, q);
    chk(q, 32'h10, "speed readback");
    wr(`ATL_IDX_SPEED, 8'h00);
    $display("test tone done");
    // Rates stay nonzero; channel tie is outside this block
    wr(`ATL_IDX_TONE, 8'h20);
    wr(`ATL_IDX_ATTACK_RATE_VALUE, 8'h10);
    wr(`ATL_IDX_LIMITER_RELEASE_RATE, 8'h80);
    wr(`ATL_IDX_MODE, 8'h03);
    ticks(2);
    clip_detect <= 1'b1;
    gap(1'b0, n);
    chk_n(n, 2 * PER, "attack pace");
    chk(bass_gain, 0, "boost cut first");
    ticks(20);
    clip_detect <= 1'b0;
    gap(1'b0, n);
    chk_n(n, 4 * PER, "release pace");
    ticks(140);
    chk(limiter_atten, 0, "attenuation restored");
    chk(bass_gain, 16, "bass restored");
    wr(`ATL_IDX_MODE, 8'h00);
    $display("test limiter done");
    chk(ramp_done, 1, "ramp idle at bias floor");
    ramp_up_req <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(`ATL_IDX_RAMPMIX, {2'b00, s[1:0], 4'h9});
      gap(1'b1, n);
      chk_n(n, rstep[s], "ramp step");
    end
    chk(ramp_done, 0, "ramp still running");
    ramp_up_req <= 1'b0;
    pb = pwm_duty;
    ticks(60);
    chk(pwm_duty < pb, 1, "ramp down");
    $display("test ramp done");
    print_verdict;
  end
endmodule // atl_top_bench
